// [bench/pswd_host_model.sv]
// pswd_host_model: host processor that toggles the kick pin.
// assumes the bench raises run only while the host is meant to be alive
`timescale 1ns/1ps
module pswd_host_model #(
   parameter int HALF = 10
) (
   input wire logic mclk,
   input wire logic run,
   output logic kick_in
);
   int cnt = 0;
   initial kick_in = 1'b0;
   // toggle well inside each timeout period while running
   always @(negedge mclk) begin
      if (run) begin
         cnt = cnt + 1;
         if (cnt >= HALF) begin
            cnt = 0;
            kick_in <= ~kick_in;
         end
      end else begin
         cnt = 0;
      end
   end
endmodule

// [bench/test_pswd_top.sv]
// test_pswd_top: self-checking bench for the watchdog, short variant.
// assumes one microsecond per cycle and a push-pull alarm pin
`timescale 1ns/1ps
module test_pswd_top;
   localparam int SETTLE = int'(pswd_pkg::T_SETTLE_US);
   localparam int DLY = int'(pswd_pkg::T_200US);
   localparam int WD = int'(pswd_pkg::T_30US);
   localparam int PULSE = int'(pswd_pkg::T_PULSE_PP_US);
   localparam int HALF = 10;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [2:0] sel = 3'h4;
   logic run = 1'b0;
   logic kick;
   logic alarm_n;
   logic oe;
   logic pin;
   int error_cnt = 0;
   int check_count = 0;
   int n;

   always #12.5 mclk = ~mclk;
   // pull-up holds the line high while undriven
   assign pin = oe ? alarm_n : 1'b1;

   pswd_host_model #(.HALF(HALF)) i_host (
      .mclk(mclk),
      .run(run),
      .kick_in(kick)
   );

   pswd_top #(
      .VARIANT(pswd_pkg::VAR_SHORT),
      .OPEN_DRAIN(1'b0),
      .CYC_PER_US(32'h1)
   ) i_dut (
      .mclk(mclk),
      .rst_n(rst_n),
      .kick_in(kick),
      .period_sel_bit0(sel[0]),
      .period_sel_bit1(sel[1]),
      .period_sel_bit2(sel[2]),
      .alarm_pulse_n(alarm_n),
      .alarm_oe(oe)
   );

   task automatic end_sim();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk_range(input int v, input int lo, input int hi);
      check_count++;
      if (v < lo || v > hi) begin
         error_cnt++;
         $display("MISMATCH %0t count %0d not in %0d..%0d", $time, v, lo, hi);
      end
   endtask

   // cycles until the pin reaches lvl, bounded by lim
   task automatic cyc_to(input logic lvl, input int lim, output int c);
      c = 0;
      while (pin !== lvl && c < lim) begin
         @(negedge mclk);
         c++;
      end
   endtask

   // pin must stay released for len cycles
   task automatic quiet(input int len);
      int lows;
      lows = 0;
      repeat (len) begin
         @(negedge mclk);
         if (pin !== 1'b1) begin
            lows++;
         end
      end
      chk_range(lows, 0, 0);
   endtask

   task automatic t_timeout();
      cyc_to(1'b0, 2000, n);
      chk_range(n, SETTLE + DLY + WD, SETTLE + DLY + WD + 10);
      cyc_to(1'b1, 2 * PULSE, n);
      chk_range(n, PULSE, PULSE);
      cyc_to(1'b0, 2000, n);
      chk_range(n, WD, WD + 4);
      cyc_to(1'b1, 2 * PULSE, n);
      chk_range(n, PULSE, PULSE);
   endtask

   task automatic t_kick();
      run = 1'b1;
      quiet(1500);
      run = 1'b0;
      cyc_to(1'b0, 2000, n);
      chk_range(n, WD - HALF, WD + 8);
      cyc_to(1'b1, 2 * PULSE, n);
      chk_range(n, PULSE, PULSE);
   endtask

   task automatic t_disable();
      sel = 3'h3;
      quiet(3000);
   endtask

   task automatic t_first_edge();
      sel = 3'h5;
      quiet(2000);
      run = 1'b1;
      repeat (HALF + 2) @(negedge mclk);
      run = 1'b0;
      quiet(1000);
   endtask

   task automatic t_sel_change();
      sel = 3'h0;
      repeat (100) @(negedge mclk);
      sel = 3'h4;
      cyc_to(1'b0, 2000, n);
      chk_range(n, SETTLE + DLY + WD, SETTLE + DLY + WD + 10);
      cyc_to(1'b1, 2 * PULSE, n);
      chk_range(n, PULSE, PULSE);
   endtask

   initial begin
      #(40000 * 25);
      error_cnt++;
      $display("MISMATCH %0t watchdog expired", $time);
      end_sim();
   end

   initial begin
      repeat (2) @(negedge mclk);
      rst_n = 1'b1;
      t_timeout();
      t_kick();
      t_disable();
      t_first_edge();
      t_sel_change();
      end_sim();
   end
endmodule

// [design/pswd_pkg.sv]
// pswd_pkg: constants, types and the setting table for the pin-select
// watchdog.
// assumes a single 40 MHz clock; all times are held in microseconds
package pswd_pkg;

   localparam int unsigned CLK_MHZ = 40;

   // family variants
   localparam logic [1:0] VAR_EQUAL = 2'h0;
   localparam logic [1:0] VAR_LONGDLY = 2'h1;
   localparam logic [1:0] VAR_SHORT = 2'h2;

   // times in microseconds, minimum figures of each window
   localparam logic [31:0] T_30US = 32'h0000001e;
   localparam logic [31:0] T_200US = 32'h000000c8;
   localparam logic [31:0] T_SETTLE_US = 32'h0000012c;
   localparam logic [31:0] T_1MS = 32'h000003e8;
   localparam logic [31:0] T_3MS = 32'h00000bb8;
   localparam logic [31:0] T_10MS = 32'h00002710;
   localparam logic [31:0] T_30MS = 32'h00007530;
   localparam logic [31:0] T_100MS = 32'h000186a0;
   localparam logic [31:0] T_300MS = 32'h000493e0;
   localparam logic [31:0] T_1S = 32'h000f4240;
   localparam logic [31:0] T_3S = 32'h002dc6c0;
   localparam logic [31:0] T_10S = 32'h00989680;
   localparam logic [31:0] T_60S = 32'h03938700;

   // alarm pulse widths
   localparam logic [31:0] T_PULSE_OD_US = T_100MS;
   localparam logic [31:0] T_PULSE_PP_US = T_1MS;

   localparam logic [2:0] SEL_OFF = 3'h3;

   typedef enum logic [1:0] {
      PSWD_TIMED = 2'h0,
      PSWD_FIRST_EDGE = 2'h1,
      PSWD_DISABLED = 2'h2
   } pswd_mode_e;

   typedef struct packed {
      pswd_mode_e mode;
      logic [31:0] dly_us;
      logic [31:0] wd_us;
   } pswd_cfg_s;

   typedef enum logic [2:0] {
      PSWD_ST_SETTLE = 3'h0,
      PSWD_ST_DELAY = 3'h1,
      PSWD_ST_FIRST = 3'h2,
      PSWD_ST_WATCH = 3'h3,
      PSWD_ST_ALARM = 3'h4,
      PSWD_ST_OFF = 3'h5
   } pswd_state_e;

   // microseconds to clock cycles, at least one cycle
   function automatic logic [31:0] us_to_cyc(input logic [31:0] us,
                                             input logic [31:0] cpu);
      logic [63:0] p;
      p = 64'(us) * 64'(cpu);
      if (p == 64'h0) begin
         p = 64'h1;
      end
      return p[31:0];
   endfunction

   // per-variant decode of the select pins
   function automatic pswd_cfg_s decode(input logic [1:0] variant,
                                        input logic [2:0] sel);
      pswd_cfg_s c;
      c.mode = PSWD_TIMED;
      c.dly_us = T_1MS;
      c.wd_us = T_1MS;
      if (sel == SEL_OFF) begin
         c.mode = PSWD_DISABLED;
      end else if (variant == VAR_EQUAL) begin
         case (sel)
            3'h0: c.wd_us = T_1MS;
            3'h1: c.wd_us = T_10MS;
            3'h2: c.wd_us = T_30MS;
            3'h4: c.wd_us = T_100MS;
            3'h5: c.wd_us = T_1S;
            3'h6: c.wd_us = T_10S;
            default: c.wd_us = T_60S;
         endcase
         c.dly_us = c.wd_us;
      end else if (variant == VAR_LONGDLY) begin
         c.dly_us = T_60S;
         case (sel)
            3'h0: c.wd_us = T_1MS;
            3'h1: c.wd_us = T_3MS;
            3'h2: c.wd_us = T_10MS;
            3'h4: c.wd_us = T_100MS;
            3'h5: c.wd_us = T_300MS;
            3'h6: c.wd_us = T_3S;
            default: c.wd_us = T_60S;
         endcase
      end else begin
         case (sel)
            3'h0: begin
               c.dly_us = T_3MS;
               c.wd_us = T_3MS;
            end
            3'h1: begin
               c.dly_us = T_3S;
               c.wd_us = T_3S;
            end
            3'h2: begin // [RULE6]
               c.dly_us = T_60S;
               c.wd_us = T_1S;
            end
            3'h4: begin // [RULE5]
               c.dly_us = T_200US;
               c.wd_us = T_30US;
            end
            3'h5: begin
               c.mode = PSWD_FIRST_EDGE;
               c.wd_us = T_1S;
            end
            3'h6: begin
               c.mode = PSWD_FIRST_EDGE;
               c.wd_us = T_10S;
            end
            default: begin
               c.dly_us = T_60S;
               c.wd_us = T_10S;
            end
         endcase
      end
      return c;
   endfunction

endpackage

// [design/pswd_sync.sv]
// pswd_sync: two-flop synchroniser for pin inputs.
// assumes the input is static or slow against mclk
`timescale 1ns/1ps
module pswd_sync #(
   parameter int unsigned W = 1
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule

// [design/pswd_top.sv]
// pswd_top: pin-select watchdog supervisor.
// assumes mclk free-running at 40 MHz; kick and select pins asynchronous.
// How it works
// [RULE1] after reset or select change, kick ignored for 300 us settle
// [RULE2] first-edge codes: no timeout counting until first kick transition
// [RULE3] alarm pulse 100 ms open-drain or 1 ms push-pull, by parameter
// [RULE4] long-delay variant: every enabled code waits 60 s first
// [RULE5] short variant code 100: 200 us delay, then 30 us timeout
// [RULE6] short variant code 010: 60 s delay, then 1 s timeout
// [RULE7] code 011 disables everything; alarm stays high
// [RULE8] any kick edge or alarm clears the timeout counter
// [RULE9] kick steady a whole period drives alarm low for pulse width
// [RULE10] startup delay runs before counting; host then kicks each period
// [RULE11] three select pins decode eight settings per variant
// [RULE12] all intervals counted in mclk cycles at their minimum figures
`timescale 1ns/1ps
module pswd_top #(
   parameter logic [1:0] VARIANT = pswd_pkg::VAR_EQUAL,
   parameter bit OPEN_DRAIN = 1'b1,
   parameter logic [31:0] CYC_PER_US = 32'(pswd_pkg::CLK_MHZ)
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic kick_in,
   input wire logic period_sel_bit0,
   input wire logic period_sel_bit1,
   input wire logic period_sel_bit2,
   output logic alarm_pulse_n,
   output logic alarm_oe
);
   logic kick_s;
   logic [2:0] sel_s;
   logic [2:0] sel_q;
   logic kick_prev_q;
   logic kick_edge;
   logic sel_chg;
   logic alarm_q;
   logic [31:0] cnt_q;
   logic [31:0] tgt;
   logic done;
   pswd_pkg::pswd_cfg_s cfg;
   pswd_pkg::pswd_state_e st_q;
   pswd_pkg::pswd_state_e st_d;

   pswd_sync #(.W(4)) u_sync (
      .mclk(mclk),
      .rst_n(rst_n),
      .d({period_sel_bit2, period_sel_bit1, period_sel_bit0, kick_in}),
      .q({sel_s, kick_s})
   );

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         kick_prev_q <= 1'b0;
         sel_q <= 3'h0;
      end else begin
         kick_prev_q <= kick_s;
         sel_q <= sel_s;
      end
   end

   assign kick_edge = kick_s ^ kick_prev_q;
   assign sel_chg = sel_s != sel_q;
   assign cfg = pswd_pkg::decode(VARIANT, sel_q); // [RULE11] [RULE4]

   // interval for the current state
   always_comb begin
      case (st_q)
         pswd_pkg::PSWD_ST_SETTLE:
            tgt = pswd_pkg::us_to_cyc(pswd_pkg::T_SETTLE_US, CYC_PER_US);
         pswd_pkg::PSWD_ST_DELAY:
            tgt = pswd_pkg::us_to_cyc(cfg.dly_us, CYC_PER_US); // [RULE12]
         pswd_pkg::PSWD_ST_ALARM:
            tgt = pswd_pkg::us_to_cyc(OPEN_DRAIN ? pswd_pkg::T_PULSE_OD_US :
                                      pswd_pkg::T_PULSE_PP_US,
                                      CYC_PER_US); // [RULE3]
         default:
            tgt = pswd_pkg::us_to_cyc(cfg.wd_us, CYC_PER_US); // [RULE12]
      endcase
   end

   assign done = cnt_q >= tgt - 32'h1;

   always_comb begin
      st_d = st_q;
      if (sel_chg) begin
         st_d = pswd_pkg::PSWD_ST_SETTLE; // [RULE1]
      end else begin
         case (st_q)
            pswd_pkg::PSWD_ST_SETTLE: begin
               if (done) begin
                  case (cfg.mode)
                     pswd_pkg::PSWD_DISABLED:
                        st_d = pswd_pkg::PSWD_ST_OFF; // [RULE7]
                     pswd_pkg::PSWD_FIRST_EDGE:
                        st_d = pswd_pkg::PSWD_ST_FIRST; // [RULE2]
                     default:
                        st_d = pswd_pkg::PSWD_ST_DELAY; // [RULE10]
                  endcase
               end
            end
            pswd_pkg::PSWD_ST_DELAY: begin
               if (done) begin
                  st_d = pswd_pkg::PSWD_ST_WATCH; // [RULE10]
               end
            end
            pswd_pkg::PSWD_ST_FIRST: begin
               if (kick_edge) begin
                  st_d = pswd_pkg::PSWD_ST_WATCH; // [RULE2]
               end
            end
            pswd_pkg::PSWD_ST_WATCH: begin
               if (!kick_edge && done) begin
                  st_d = pswd_pkg::PSWD_ST_ALARM; // [RULE9]
               end
            end
            pswd_pkg::PSWD_ST_ALARM: begin
               if (done) begin
                  st_d = pswd_pkg::PSWD_ST_WATCH; // [RULE9]
               end
            end
            pswd_pkg::PSWD_ST_OFF: st_d = pswd_pkg::PSWD_ST_OFF;
            default: st_d = pswd_pkg::PSWD_ST_SETTLE;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= pswd_pkg::PSWD_ST_SETTLE;
      end else begin
         st_q <= st_d;
      end
   end

   // interval counter, restarted on every state change
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 32'h0;
      end else if (st_d != st_q || sel_chg) begin
         cnt_q <= 32'h0; // [RULE8] [RULE1]
      end else if (st_q == pswd_pkg::PSWD_ST_WATCH && kick_edge) begin
         cnt_q <= 32'h0; // [RULE8]
      end else if (st_q == pswd_pkg::PSWD_ST_FIRST ||
                   st_q == pswd_pkg::PSWD_ST_OFF) begin
         cnt_q <= 32'h0; // [RULE2]
      end else begin
         cnt_q <= cnt_q + 32'h1;
      end
   end

   // alarm pin: open-drain pulls low, push-pull drives whenever out of reset
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         alarm_q <= 1'b0;
         alarm_pulse_n <= 1'b1;
         alarm_oe <= 1'b0;
      end else begin
         alarm_q <= st_d == pswd_pkg::PSWD_ST_ALARM;
         alarm_pulse_n <= OPEN_DRAIN ? 1'b0 :
                          !(st_d == pswd_pkg::PSWD_ST_ALARM); // [RULE3]
         alarm_oe <= OPEN_DRAIN ? (st_d == pswd_pkg::PSWD_ST_ALARM) : 1'b1;
      end
   end

   a_settle_ignore: assert property (@(posedge mclk) // [RULE1]
      disable iff (!rst_n)
      st_q == pswd_pkg::PSWD_ST_SETTLE && st_d == st_q && !sel_chg
      |=> cnt_q == $past(cnt_q) + 32'h1)
      else $error("settle count disturbed by kick");

   a_settle_restart: assert property (@(posedge mclk) // [RULE1]
      disable iff (!rst_n)
      sel_chg |=> st_q == pswd_pkg::PSWD_ST_SETTLE && cnt_q == 32'h0)
      else $error("select change did not restart settle");

   a_first_hold: assert property (@(posedge mclk) // [RULE2]
      disable iff (!rst_n)
      st_q == pswd_pkg::PSWD_ST_FIRST && !kick_edge && !sel_chg
      |=> st_q == pswd_pkg::PSWD_ST_FIRST && cnt_q == 32'h0)
      else $error("first-edge wait left without an edge");

   a_first_go: assert property (@(posedge mclk) // [RULE2]
      disable iff (!rst_n)
      st_q == pswd_pkg::PSWD_ST_FIRST && kick_edge && !sel_chg
      |=> st_q == pswd_pkg::PSWD_ST_WATCH && cnt_q == 32'h0)
      else $error("first edge did not start supervision");

   a_pulse_end: assert property (@(posedge mclk) // [RULE3]
      disable iff (!rst_n)
      st_q == pswd_pkg::PSWD_ST_ALARM && done && !sel_chg
      |=> !alarm_q && (OPEN_DRAIN ? !alarm_oe : alarm_pulse_n))
      else $error("alarm pulse did not end on time");

   a_pulse_held: assert property (@(posedge mclk) // [RULE3]
      disable iff (!rst_n)
      st_q == pswd_pkg::PSWD_ST_ALARM && !done && !sel_chg
      |=> alarm_q && !alarm_pulse_n && alarm_oe)
      else $error("alarm released early");

   a_kick_clear: assert property (@(posedge mclk) // [RULE8]
      disable iff (!rst_n)
      st_q == pswd_pkg::PSWD_ST_WATCH && kick_edge && !sel_chg
      |=> cnt_q == 32'h0 && st_q == pswd_pkg::PSWD_ST_WATCH)
      else $error("kick edge did not clear timer");

   a_timeout_fire: assert property (@(posedge mclk) // [RULE9]
      disable iff (!rst_n)
      st_q == pswd_pkg::PSWD_ST_WATCH && !kick_edge && done && !sel_chg
      |=> alarm_q && alarm_oe ##1 !alarm_pulse_n)
      else $error("timeout did not raise the alarm");

   a_off_quiet: assert property (@(posedge mclk) // [RULE7]
      disable iff (!rst_n)
      st_q == pswd_pkg::PSWD_ST_OFF |-> !alarm_q && sel_q == pswd_pkg::SEL_OFF)
      else $error("disabled watchdog not quiet");

   a_delay_quiet: assert property (@(posedge mclk) // [RULE10]
      disable iff (!rst_n)
      st_q == pswd_pkg::PSWD_ST_DELAY |-> !alarm_q)
      else $error("alarm during startup delay");
endmodule
